// [design/msc_settle_timer.sv]
// oscillator settling timer for the exit from deep standby
// assumes start is a one-cycle pulse from the same clock domain
`timescale 1ns/1ps
module msc_settle_timer #(
  parameter int unsigned BASE = msc_pkg::SETTLE_BASE_STATES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [2:0] wait_sel,
  output logic done
);
  import msc_pkg::*;

  logic [SETTLE_CNT_W-1:0] base_w; // base count at counter width
  logic [SETTLE_CNT_W-1:0] target; // selected wait length
  logic [SETTLE_CNT_W-1:0] cnt_q; // remaining states
  logic [SETTLE_CNT_W-1:0] cnt_d;
  logic run_q; // wait in progress
  logic run_d;
  logic done_d;

  assign base_w = SETTLE_CNT_W'(BASE);
  // 10x and the illegal 11x both take the longest wait
  assign target = wait_sel[2] ? (base_w << 4) : (base_w << wait_sel[1:0]);

  // countdown; done pulses once the last state has passed
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = target - 1'b1;
      run_d = 1'b1;
    end else if (run_q && cnt_q == '0) begin
      run_d = 1'b0;
      done_d = 1'b1;
    end else if (run_q) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done <= done_d;
    end
  end
endmodule : msc_settle_timer

// [design/msc_top.sv]
// mode select and system control register bank with power-down sequencing
// assumes static strap pins, an asynchronous nmi pin, and cpu-side pulses
// from logic on the same clock; registers sit on an avalon-mm slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module msc_top #(
  parameter int unsigned SETTLE_BASE = msc_pkg::SETTLE_BASE_STATES
) (
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [msc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [msc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [msc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // board pins
  input wire logic [2:0] mode_strap_pins,
  input wire logic nmi_pin,
  // cpu side
  input wire logic power_down_instr,
  input wire logic wake_irq,
  input wire logic exc_entry,
  input wire logic [23:0] cpu_addr,
  // decoded mode and pin functions
  output logic [2:0] mode_number,
  output logic wide_space,
  output logic [23:0] addr_pin_enable,
  output logic bus_16bit,
  output logic port4_is_data,
  output logic porta_is_addr,
  // flag and interrupt controls
  output logic user_flag_is_mask,
  output logic set_mask_flag,
  output logic set_user_or_mask_flag,
  output logic nmi_request,
  // ram routing
  output logic onchip_ram_enable,
  output logic ram_select,
  output logic ext_select,
  // power-down state
  output logic sleep_mode,
  output logic standby_mode,
  output logic settle_busy
);
  import msc_pkg::*;

  // synchronisers and strap capture
  logic [2:0] strap_s1_q; // first stage, read only by second
  logic [2:0] strap_s2_q; // synchronised strap level
  logic [2:0] nmi_s_q; // nmi sync stages and edge history
  logic [1:0] init_cnt_q; // cycles since reset release
  logic init_done_q; // strap taken, bus open
  // registers
  logic [7:0] sys_ctrl_q; // system control
  logic [7:0] sys_ctrl_d;
  logic [7:0] area_width_q; // area width control
  logic [7:0] area_width_d;
  // bus answer
  logic wait_q;
  logic wait_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  // power-down sequencer
  msc_pd_t pd_q;
  msc_pd_t pd_d;
  logic settle_start;
  logic settle_done;

  // decode of the bus request
  wire req = avs_read | avs_write;
  wire take = req & wait_q & init_done_q; // request accepted this edge
  wire wr_fire = avs_write & ~wait_q; // write completes at this edge
  wire hit_aw = (avs_address == ADR_AREA_WIDTH);
  wire hit_ms = (avs_address == ADR_MODE_STATUS);
  wire hit_sc = (avs_address == ADR_SYS_CTRL);
  wire lane0 = avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];

  // mode decode from the synchronised straps
  wire is_m1 = (strap_s2_q == MODE1_CODE);
  wire is_m2 = (strap_s2_q == MODE2_CODE);
  wire is_m3 = (strap_s2_q == MODE3_CODE);
  wire is_m4 = (strap_s2_q == MODE4_CODE);
  wire big_space = is_m3 | is_m4; // 16 mbytes
  wire init_wide_bus = is_m2 | is_m4; // 16-bit initial bus
  wire [2:0] mode_num = is_m1 ? 3'h1 : is_m2 ? 3'h2 : is_m3 ? 3'h3 : is_m4 ? 3'h4 : 3'h0;
  wire [23:0] addr_en = big_space ? ADDR_EN_16M : ADDR_EN_1M;
  // any word-wide area widens the bus, all byte-wide narrows it
  wire bus_wide = ~(&area_width_q);

  // control fields
  wire deep_standby_select = sys_ctrl_q[SC_STBY_BIT];
  wire [2:0] settle_wait_select = sys_ctrl_q[SC_WAIT_HI:SC_WAIT_LO];
  wire user_flag_enable = sys_ctrl_q[SC_UE_BIT];
  wire nmi_edge_select = sys_ctrl_q[SC_NMI_BIT];
  wire ram_en = sys_ctrl_q[SC_RAM_BIT];

  // ram window match for the current space size
  wire [23:0] ram_lo = big_space ? RAM_LO_16M : RAM_LO_1M;
  wire [23:0] ram_hi = big_space ? RAM_HI_16M : RAM_HI_1M;
  wire in_ram = (cpu_addr >= ram_lo) && (cpu_addr <= ram_hi);

  // nmi edge detect on synchronised samples only
  wire nmi_rise = nmi_s_q[1] & ~nmi_s_q[2];
  wire nmi_fall = ~nmi_s_q[1] & nmi_s_q[2];
  wire nmi_hit = nmi_edge_select ? nmi_rise : nmi_fall;

  // status image: fixed high bits, zeros, then the pin levels
  wire [7:0] status_img = MS_FIXED_ONES | {5'h00, strap_s2_q};

  // strap synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
    end else begin
      strap_s1_q <= mode_strap_pins;
      strap_s2_q <= strap_s1_q;
    end
  end

  // nmi synchroniser plus one history stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_s_q <= 3'h0;
    end else begin
      nmi_s_q <= {nmi_s_q[1:0], nmi_pin};
    end
  end

  // holds the bus off until the strap has passed the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_q <= 2'h0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      init_done_q <= (init_cnt_q == INIT_CYCLES);
    end
  end

  // system control next value: only writable bits change
  always_comb begin
    sys_ctrl_d = sys_ctrl_q;
    if (wr_fire && hit_sc && lane0) begin
      sys_ctrl_d = (wbyte & SC_WRITE_MASK) | SC_FIXED_ONES;
    end
  end

  // area width next value; initial value follows the strapped mode
  always_comb begin
    area_width_d = area_width_q;
    if (!init_done_q && init_cnt_q == INIT_CYCLES) begin
      area_width_d = init_wide_bus ? AW_ALL_WORD : AW_ALL_BYTE;
    end else if (wr_fire && hit_aw && lane0) begin
      area_width_d = wbyte;
    end
  end

  // system control register; standby never touches it, so the ram
  // and standby bits keep their values across deep standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_ctrl_q <= SC_RESET;
    end else begin
      sys_ctrl_q <= sys_ctrl_d;
    end
  end

  // area width control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      area_width_q <= AW_ALL_BYTE;
    end else begin
      area_width_q <= area_width_d;
    end
  end

  // read mux; mode status has no write path at all, and its pin
  // levels are captured into the read data at the accepting edge
  always_comb begin
    rdata_d = rdata_q;
    if (take && avs_read) begin
      rdata_d = '0;
      if (hit_ms) begin
        rdata_d[7:0] = status_img;
      end else if (hit_sc) begin
        rdata_d[7:0] = sys_ctrl_q | SC_FIXED_ONES;
      end else if (hit_aw) begin
        rdata_d[7:0] = area_width_q;
      end
    end
  end

  // one-cycle answer: waitrequest drops for exactly one cycle
  always_comb begin
    wait_d = 1'b1;
    if (take) begin
      wait_d = 1'b0;
    end
  end

  // bus answer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // power-down sequencing
  always_comb begin
    pd_d = pd_q;
    settle_start = 1'b0;
    case (pd_q)
      PD_RUN: begin
        if (power_down_instr) begin
          pd_d = deep_standby_select ? PD_STANDBY : PD_SLEEP;
        end
      end
      PD_SLEEP: begin
        if (wake_irq | nmi_hit) begin
          pd_d = PD_RUN;
        end
      end
      PD_STANDBY: begin
        if (wake_irq | nmi_hit) begin
          pd_d = PD_SETTLE;
          settle_start = 1'b1;
        end
      end
      PD_SETTLE: begin
        if (settle_done) begin
          pd_d = PD_RUN;
        end
      end
      default: begin
        pd_d = PD_RUN;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= PD_RUN;
    end else begin
      pd_q <= pd_d;
    end
  end

  // settling wait counter
  msc_settle_timer #(
    .BASE(SETTLE_BASE)
  ) u_settle (
    .clk(clk),
    .rst_n(rst_n),
    .start(settle_start),
    .wait_sel(settle_wait_select),
    .done(settle_done)
  );

  // registered decoded outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_number <= 3'h0;
      wide_space <= 1'b0;
      addr_pin_enable <= 24'h000000;
      bus_16bit <= 1'b0;
      port4_is_data <= 1'b0;
      porta_is_addr <= 1'b0;
    end else begin
      mode_number <= mode_num;
      wide_space <= big_space;
      addr_pin_enable <= addr_en;
      bus_16bit <= bus_wide;
      port4_is_data <= bus_wide;
      porta_is_addr <= big_space;
    end
  end

  // registered flag, interrupt and ram routing outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_flag_is_mask <= 1'b0;
      set_mask_flag <= 1'b0;
      set_user_or_mask_flag <= 1'b0;
      nmi_request <= 1'b0;
      onchip_ram_enable <= 1'b1;
      ram_select <= 1'b0;
      ext_select <= 1'b0;
    end else begin
      user_flag_is_mask <= ~user_flag_enable;
      set_mask_flag <= exc_entry;
      set_user_or_mask_flag <= exc_entry & ~user_flag_enable;
      nmi_request <= nmi_hit;
      onchip_ram_enable <= ram_en;
      ram_select <= in_ram & ram_en;
      ext_select <= ~(in_ram & ram_en);
    end
  end

  // registered power-down outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      settle_busy <= 1'b0;
    end else begin
      sleep_mode <= (pd_d == PD_SLEEP);
      standby_mode <= (pd_d == PD_STANDBY);
      settle_busy <= (pd_d == PD_SETTLE);
    end
  end

  // bus outputs straight from flops
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;
endmodule : msc_top

// [dv/msc_board_model.sv]
// board side: strap pins and the nmi line
// assumes the bench changes the strap code only while reset is held
`timescale 1ns/1ps
module msc_board_model (
  input wire logic [2:0] mode_code,
  input wire logic nmi_level,
  output logic [2:0] mode_strap_pins,
  output logic nmi_pin
);
  // straps are hard levels, one of the four valid codes, fixed while running
  assign mode_strap_pins = mode_code;
  // nmi line follows the requested level
  assign nmi_pin = nmi_level;
endmodule : msc_board_model

// [dv/msc_top_asserts.sv]
// checker for the mode select and system control bank
// assumes it is bound into msc_top and sees only that module's ports
`timescale 1ns/1ps
module msc_top_checker
  import msc_pkg::*;
#(
  parameter int unsigned SETTLE_BASE = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [msc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic [msc_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] mode_strap_pins,
  input wire logic power_down_instr,
  input wire logic exc_entry,
  input wire logic [2:0] mode_number,
  input wire logic wide_space,
  input wire logic [23:0] addr_pin_enable,
  input wire logic bus_16bit,
  input wire logic port4_is_data,
  input wire logic porta_is_addr,
  input wire logic user_flag_is_mask,
  input wire logic set_mask_flag,
  input wire logic set_user_or_mask_flag,
  input wire logic nmi_request,
  input wire logic onchip_ram_enable,
  input wire logic ram_select,
  input wire logic sleep_mode,
  input wire logic standby_mode,
  input wire logic settle_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // completing reads of the two registers
  wire rd_ms = avs_read && !avs_waitrequest && avs_address == ADR_MODE_STATUS;
  wire rd_sc = avs_read && !avs_waitrequest && avs_address == ADR_SYS_CTRL;
  logic [22:0] busy_q; // cycles spent settling so far
  // count the settle time so its length can be bounded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) busy_q <= 23'h0;
    else busy_q <= settle_busy ? busy_q + 23'h1 : 23'h0;
  end
  chk_status_bits: assert property (
    rd_ms |-> avs_readdata[7:0] == {5'h18, mode_strap_pins}) else $error("mode status read wrong");
  chk_rsv_one: assert property (rd_sc |-> avs_readdata[1]) else $error("reserved bit not one");
  chk_sc_fields: assert property (
    rd_sc |-> avs_readdata[3] != user_flag_is_mask && avs_readdata[0] == onchip_ram_enable)
    else $error("control outputs differ from register");
  chk_ram_route: assert property (
    (!onchip_ram_enable && $past(onchip_ram_enable) == 1'b0) |-> !ram_select) else $error("ram selected while off");
  chk_mode_wide: assert property (
    mode_number != 3'h0 |-> wide_space == (mode_number >= MODE3_CODE)) else $error("space size wrong");
  chk_space_pins: assert property (
    mode_number != 3'h0 |-> addr_pin_enable == (wide_space ? ADDR_EN_16M : ADDR_EN_1M) && porta_is_addr == wide_space)
    else $error("address pins wrong");
  chk_port4_bus: assert property (port4_is_data == bus_16bit) else $error("port 4 use wrong");
  chk_exc_mask: assert property (
    exc_entry |=> set_mask_flag && set_user_or_mask_flag == $past(user_flag_is_mask)) else $error("exception flags wrong");
  chk_pd_entry: assert property (
    power_down_instr && !sleep_mode && !standby_mode && !settle_busy |=> sleep_mode || standby_mode)
    else $error("power down not entered");
  chk_settle_len: assert property (busy_q <= 23'(SETTLE_BASE * 16 + 1)) else $error("settle too long");
  chk_nmi_pulse: assert property (nmi_request |=> !nmi_request) else $error("nmi request too long");
  cover property (rd_ms);
  cover property (standby_mode);
  cover property (exc_entry && user_flag_is_mask);
endmodule : msc_top_checker
bind msc_top msc_top_checker #(.SETTLE_BASE(SETTLE_BASE)) u_chk (.clk(clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mode_strap_pins(mode_strap_pins), .power_down_instr(power_down_instr), .exc_entry(exc_entry),
  .mode_number(mode_number), .wide_space(wide_space), .addr_pin_enable(addr_pin_enable), .bus_16bit(bus_16bit),
  .port4_is_data(port4_is_data), .porta_is_addr(porta_is_addr), .user_flag_is_mask(user_flag_is_mask),
  .set_mask_flag(set_mask_flag), .set_user_or_mask_flag(set_user_or_mask_flag), .nmi_request(nmi_request),
  .onchip_ram_enable(onchip_ram_enable), .ram_select(ram_select), .sleep_mode(sleep_mode),
  .standby_mode(standby_mode), .settle_busy(settle_busy));

// [dv/testbench.sv]
// self-checking bench for the mode select and system control bank
// assumes msc_top with a short settle base and the board model beside it
`timescale 1ns/1ps
module testbench;
  import msc_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, nmi_level, nmi, power_down_instr, wake_irq, exc_entry;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, w, seed;
  logic [3:0] avs_byteenable;
  logic [2:0] mode_code, strap, mode_number;
  logic [23:0] cpu_addr, addr_pin_enable;
  logic wide_space, bus_16bit, port4_is_data, porta_is_addr, user_flag_is_mask, set_mask_flag;
  logic set_user_or_mask_flag, nmi_request, onchip_ram_enable, ram_select, ext_select;
  logic sleep_mode, standby_mode, settle_busy;
  int n_fail, num_checks, cyc, cnt;
  msc_board_model board (.mode_code(mode_code), .nmi_level(nmi_level), .mode_strap_pins(strap), .nmi_pin(nmi));
  msc_top #(.SETTLE_BASE(8)) uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mode_strap_pins(strap), .nmi_pin(nmi),
    .power_down_instr(power_down_instr), .wake_irq(wake_irq), .exc_entry(exc_entry), .cpu_addr(cpu_addr),
    .mode_number(mode_number), .wide_space(wide_space), .addr_pin_enable(addr_pin_enable), .bus_16bit(bus_16bit),
    .port4_is_data(port4_is_data), .porta_is_addr(porta_is_addr), .user_flag_is_mask(user_flag_is_mask),
    .set_mask_flag(set_mask_flag), .set_user_or_mask_flag(set_user_or_mask_flag), .nmi_request(nmi_request),
    .onchip_ram_enable(onchip_ram_enable), .ram_select(ram_select), .ext_select(ext_select),
    .sleep_mode(sleep_mode), .standby_mode(standby_mode), .settle_busy(settle_busy));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // xorshift source for random register values
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // expected control register after a write
  function automatic logic [31:0] exp_sc(input logic [31:0] v);
    return {24'h0, (v[7:0] & SC_WRITE_MASK) | SC_FIXED_ONES};
  endfunction : exp_sc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // no local limit: only the bench cycle ceiling ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // reset with a new strap code applied while held
  task automatic do_reset(input int m);
    @(posedge clk);
    rst_n <= 1'b0;
    mode_code <= m[2:0];
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(8);
  endtask : do_reset
  // one-cycle pulse on a cpu-side input: 0 power down, 1 wake, 2 exception
  task automatic pulse(input int k);
    @(posedge clk);
    {exc_entry, wake_irq, power_down_instr} <= 3'h1 << k;
    @(posedge clk);
    {exc_entry, wake_irq, power_down_instr} <= 3'h0;
    #1;
  endtask : pulse
  // cycle limit cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {rst_n, avs_read, avs_write, nmi_level, power_down_instr, wake_irq, exc_entry} = 7'h0;
    avs_address = '0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    mode_code = 3'h1;
    cpu_addr = 24'h0;
    seed = 32'h11F8;
    // each valid strap code 1 to 4: decode, status, reset value, bus width switching
    for (int m = 1; m <= 4; m++) begin
      do_reset(m);
      chk("mode", m, mode_number);
      chk("addr_en", m >= 3 ? ADDR_EN_16M : ADDR_EN_1M, addr_pin_enable);
      chk("porta", m >= 3, porta_is_addr);
      chk("bus16_init", m % 2 == 0, bus_16bit);
      bus(1'b0, ADR_MODE_STATUS, 32'h0, rd);
      chk("status", {27'h18, m[2:0]}, rd);
      bus(1'b0, ADR_SYS_CTRL, 32'h0, rd);
      chk("sc_reset", SC_RESET, rd);
      bus(1'b1, ADR_AREA_WIDTH, (m % 2) ? 32'h7F : 32'hFF, rd);
      tick(2);
      chk("bus16_sw", m % 2, bus_16bit);
      chk("port4", m % 2, port4_is_data);
      bus(1'b1, ADR_MODE_STATUS, 32'h3F, rd);
      bus(1'b0, ADR_MODE_STATUS, 32'h0, rd);
      chk("status_ro", {27'h18, m[2:0]}, rd);
      // a write without byte lane 0 must leave the control register alone
      avs_byteenable <= 4'hE;
      bus(1'b1, ADR_SYS_CTRL, 32'h00, rd);
      avs_byteenable <= 4'hF;
      bus(1'b0, ADR_SYS_CTRL, 32'h0, rd);
      chk("sc_lane", SC_RESET, rd);
      bus(1'b0, ADR_SYS_CTRL + 18'h4, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
    end
    // random control and area width values, all-byte corner first
    for (int i = 0; i < 12; i++) begin
      w = xs();
      if (w[6]) w[5] = 1'b0; // never the illegal settle code
      bus(1'b1, ADR_SYS_CTRL, w, rd);
      // odd passes sit just above the ram window
      cpu_addr <= i[0] ? RAM_HI_16M + 24'h1 : RAM_LO_16M;
      bus(1'b0, ADR_SYS_CTRL, 32'h0, rd);
      chk("sc", exp_sc(w), rd);
      chk("ram_en", w[0], onchip_ram_enable);
      chk("ue", !w[3], user_flag_is_mask);
      chk("ram_sel", w[0] & !i[0], ram_select);
      chk("ext_sel", !(w[0] & !i[0]), ext_select);
      w = (i == 0) ? {24'h0, AW_ALL_BYTE} : xs();
      bus(1'b1, ADR_AREA_WIDTH, w, rd);
      tick(2);
      chk("bus16_rand", w[7:0] != AW_ALL_BYTE, bus_16bit);
    end
    // exception entry with the user flag as mask and as user bit
    for (int u = 0; u < 2; u++) begin
      bus(1'b1, ADR_SYS_CTRL, u ? 32'h09 : 32'h01, rd);
      pulse(2);
      chk("mask", 1, set_mask_flag);
      chk("ui", !u, set_user_or_mask_flag);
    end
    // nmi: valid edge gives one request, the opposite edge none
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, ADR_SYS_CTRL, 32'h09 | (e << 2), rd);
      for (int s = 0; s < 3; s++) begin
        @(posedge clk);
        nmi_level <= (s == 1) ? e[0] : !e[0];
        cnt = 0;
        repeat (8) begin
          tick(1);
          if (nmi_request === 1'b1) cnt++;
        end
        if (s > 0) chk("nmi_count", s == 1, cnt);
      end
    end
    // deep standby and settle length for selects 0 to 4
    for (int s = 0; s <= 4; s++) begin
      w = 32'h89 | (s << 4);
      bus(1'b1, ADR_SYS_CTRL, w, rd);
      pulse(0);
      chk("standby", 1, standby_mode);
      pulse(1);
      cnt = 0;
      while (settle_busy === 1'b1 && cnt < 300) begin
        tick(1);
        cnt++;
      end
      chk("settle", (8 << (s > 3 ? 4 : s)) + 1, cnt);
      bus(1'b0, ADR_SYS_CTRL, 32'h0, rd);
      chk("sc_kept", exp_sc(w), rd);
    end
    // sleep entry and wake
    bus(1'b1, ADR_SYS_CTRL, 32'h0B, rd);
    pulse(0);
    chk("sleep", 1, sleep_mode);
    pulse(1);
    chk("sleep_exit", 0, sleep_mode);
    final_report();
  end
endmodule : testbench

// [pkg/msc_pkg.sv]
// mode select and system control: shared constants and types
// assumes a 32-bit avalon-mm slave port and one system clock
package msc_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_AREA_WIDTH = 16'hFFF0;
  localparam logic [15:0] IDX_MODE_STATUS = 16'hFFF1;
  localparam logic [15:0] IDX_SYS_CTRL = 16'hFFF2;
  localparam logic [ADDR_W-1:0] ADR_AREA_WIDTH = {IDX_AREA_WIDTH, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MODE_STATUS = {IDX_MODE_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_SYS_CTRL = {IDX_SYS_CTRL, 2'b00};
  // system control field positions
  localparam int unsigned SC_STBY_BIT = 7;
  localparam int unsigned SC_WAIT_HI = 6;
  localparam int unsigned SC_WAIT_LO = 4;
  localparam int unsigned SC_UE_BIT = 3;
  localparam int unsigned SC_NMI_BIT = 2;
  localparam int unsigned SC_RSV_BIT = 1;
  localparam int unsigned SC_RAM_BIT = 0;
  // system control reset value and writable bits
  localparam logic [7:0] SC_RESET = 8'h0B;
  localparam logic [7:0] SC_WRITE_MASK = 8'hFD;
  localparam logic [7:0] SC_FIXED_ONES = 8'h02;
  // mode status fixed bits and pin field
  localparam logic [7:0] MS_FIXED_ONES = 8'hC0;
  localparam int unsigned MS_PIN_W = 3;
  // strap codes
  localparam logic [2:0] MODE1_CODE = 3'h1;
  localparam logic [2:0] MODE2_CODE = 3'h2;
  localparam logic [2:0] MODE3_CODE = 3'h3;
  localparam logic [2:0] MODE4_CODE = 3'h4;
  // address pin enables for the two space sizes
  localparam logic [23:0] ADDR_EN_1M = 24'h0FFFFF;
  localparam logic [23:0] ADDR_EN_16M = 24'hFFFFFF;
  // area width control: one bit per area, 1 = byte wide
  localparam logic [7:0] AW_ALL_BYTE = 8'hFF;
  localparam logic [7:0] AW_ALL_WORD = 8'h00;
  // on-chip ram window per space size
  localparam logic [23:0] RAM_LO_1M = 24'h0F0000;
  localparam logic [23:0] RAM_HI_1M = 24'h0F03FF;
  localparam logic [23:0] RAM_LO_16M = 24'hFF0000;
  localparam logic [23:0] RAM_HI_16M = 24'hFF03FF;
  // settling wait, in states of the system clock
  localparam int unsigned SETTLE_BASE_STATES = 8192;
  localparam int unsigned SETTLE_CNT_W = 18;
  // cycles after reset release before the strap is taken
  localparam logic [1:0] INIT_CYCLES = 2'h3;
  // power-down sequencing, one bit changes per step except run to standby
  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_SLEEP = 2'b01,
    PD_STANDBY = 2'b11,
    PD_SETTLE = 2'b10
  } msc_pd_t;
endpackage : msc_pkg
